// file: src/bsb_core.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "bsb_defs.svh"
module bsb_core
   import bsb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] dst_addr,
   input wire logic [7:0] src_field,
   output logic instr_ready,
   output logic instr_done,
   output logic [7:0] rf_raddr,
   input wire logic [7:0] rf_rdata,
   output logic rf_we,
   output logic [7:0] rf_waddr,
   output logic [7:0] rf_wdata,
   output logic [7:0] flags,
   output logic bank_sel
);
   typedef struct packed {
      bsb_state_e state;
      logic [3:0] cnt;
      logic [3:0] len;
      logic is_sbc;
      logic is_bank;
      logic bank_val;
      bsb_src_e mode;
      logic [7:0] dst_a;
      logic [7:0] src_f;
      logic [7:0] ptr;
      logic [7:0] dval;
      logic [7:0] sval;
      logic [2:0] phase;
      logic [7:0] flags;
      logic we;
      logic [7:0] waddr;
      logic [7:0] wdata;
      logic done;
   } bsb_st_s;

   bsb_st_s st_reg;
   bsb_st_s st_next;
   logic [7:0] alu_res;
   logic alu_borrow;
   logic alu_hb;
   logic alu_ov;

   function automatic logic is_sbc_op(input logic [7:0] op);
      is_sbc_op = (op >= `BSB_OP_SBC_RR) && (op <= `BSB_OP_SBC_GIM);
   endfunction

   function automatic bsb_src_e src_mode(input logic [7:0] op);
      unique case (op)
         `BSB_OP_SBC_RIR, `BSB_OP_SBC_GIG: src_mode = BSB_SRC_INDIRECT;
         `BSB_OP_SBC_GIM: src_mode = BSB_SRC_IMM;
         default: src_mode = BSB_SRC_DIRECT;
      endcase
   endfunction

   bsb_sbc_alu #(.W(8)) u_alu
   (
      .dst(st_reg.dval),
      .src(st_reg.sval),
      .carry_in(st_reg.flags[`BSB_FLAG_C]),
      .result(alu_res),
      .borrow(alu_borrow),
      .half_borrow(alu_hb),
      .overflow(alu_ov)
   );

   // ==========================================
   // next state
   always_comb
   begin
      st_next = st_reg;
      st_next.we = 1'b0;
      st_next.done = 1'b0;
      st_next.cnt = st_reg.cnt + 4'd1;
      rf_raddr = st_reg.dst_a;
      unique case (st_reg.state)
         BSB_IDLE:
         begin
            st_next.cnt = 4'd1;
            if (instr_valid)
            begin
               st_next.dst_a = dst_addr;
               st_next.src_f = src_field;
               st_next.phase = 3'd0;
               st_next.is_sbc = is_sbc_op(opcode);
               st_next.is_bank = (opcode == `BSB_OP_SEL_BANK1) ||
                  (opcode == `BSB_OP_SEL_BANK0);
               st_next.bank_val = (opcode == `BSB_OP_SEL_BANK1);
               st_next.mode = src_mode(opcode);
               st_next.len = (opcode == `BSB_OP_SBC_RR || st_next.is_bank) ?
                  `BSB_CYC_SHORT : `BSB_CYC_LONG;
               st_next.state = BSB_FETCH;
            end
         end
         BSB_FETCH:
         begin
            // phase 0 reads dst, 1 reads src or pointer, 2 reads through pointer
            if (st_reg.is_sbc)
            begin
               unique case (st_reg.phase)
                  3'd0:
                  begin
                     rf_raddr = st_reg.dst_a;
                     st_next.dval = rf_rdata;
                     st_next.phase = 3'd1;
                  end
                  3'd1:
                  begin
                     rf_raddr = st_reg.src_f;
                     if (st_reg.mode == BSB_SRC_IMM)
                     begin
                        st_next.sval = st_reg.src_f;
                        st_next.phase = 3'd3;
                     end
                     else if (st_reg.mode == BSB_SRC_INDIRECT)
                     begin
                        st_next.ptr = rf_rdata;
                        st_next.phase = 3'd2;
                     end
                     else
                     begin
                        st_next.sval = rf_rdata;
                        st_next.phase = 3'd3;
                     end
                  end
                  3'd2:
                  begin
                     rf_raddr = st_reg.ptr;
                     st_next.sval = rf_rdata;
                     st_next.phase = 3'd3;
                  end
                  default:
                     st_next.phase = 3'd3;
               endcase
               if (st_next.phase == 3'd3)
                  st_next.state = BSB_EXEC;
            end
            else
            begin
               st_next.state = BSB_EXEC;
            end
         end
         BSB_EXEC:
         begin
            if (st_reg.is_sbc)
            begin
               st_next.we = 1'b1;
               st_next.waddr = st_reg.dst_a;
               st_next.wdata = alu_res;
               st_next.flags[`BSB_FLAG_C] = alu_borrow;
               st_next.flags[`BSB_FLAG_Z] = (alu_res == 8'h00);
               st_next.flags[`BSB_FLAG_S] = alu_res[7];
               st_next.flags[`BSB_FLAG_V] = alu_ov;
               st_next.flags[`BSB_FLAG_D] = 1'b1;
               st_next.flags[`BSB_FLAG_H] = alu_hb;
            end
            else if (st_reg.is_bank)
            begin
               // only the bank bit moves; no second bank needs to exist
               st_next.flags[`BSB_FLAG_BANK] = st_reg.bank_val;
            end
            if (st_reg.cnt >= st_reg.len - 4'd1)
            begin
               // the short subtract has no padding left: done rides with the write
               st_next.done = 1'b1;
               st_next.state = BSB_IDLE;
            end
            else
            begin
               st_next.state = BSB_DONE;
            end
         end
         BSB_DONE:
         begin
            // pad to the instruction's fixed length, taken to next take
            if (st_reg.cnt >= st_reg.len - 4'd1)
            begin
               st_next.done = 1'b1;
               st_next.state = BSB_IDLE;
            end
         end
      endcase
      if (!rst_n)
      begin
         st_next = '0;
         st_next.state = BSB_IDLE;
         st_next.flags = `BSB_FLAGS_RST;
      end
   end

   always_ff @(posedge core_clk)
   begin
      st_reg <= st_next;
   end

   assign instr_ready = (st_reg.state == BSB_IDLE);
   assign instr_done = st_reg.done;
   assign rf_we = st_reg.we;
   assign rf_waddr = st_reg.waddr;
   assign rf_wdata = st_reg.wdata;
   assign flags = st_reg.flags;
   assign bank_sel = st_reg.flags[`BSB_FLAG_BANK];

   // ==========================================
   // assertions
   a_bank_one_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SEL_BANK1) |-> ##3 bank_sel)
      else $error("bank flag not set");
   a_bank_keeps_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SEL_BANK1) |->
      ##3 (flags[7:1] == $past(flags[7:1], 3)))
      else $error("bank instruction changed flags");
   a_bank_four_cyc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SEL_BANK1) |->
      !instr_done [*4] ##1 instr_done)
      else $error("bank instruction length wrong");
   a_sbc_long_cyc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SBC_GIM) |->
      !instr_done [*6] ##1 instr_done)
      else $error("six cycle instruction length wrong");
   a_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      rf_we |-> (flags[`BSB_FLAG_Z] == (rf_wdata == 8'h00)))
      else $error("zero flag mismatch");
   a_sign_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      rf_we |-> (flags[`BSB_FLAG_S] == rf_wdata[7]))
      else $error("sign flag mismatch");
   a_decimal_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      rf_we |-> flags[`BSB_FLAG_D])
      else $error("decimal flag not set");
   a_sbc_result: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state == BSB_EXEC && st_reg.is_sbc) |->
      ##1 (rf_wdata == 8'(st_reg.dval - st_reg.sval - 8'($past(flags[`BSB_FLAG_C])))
      && flags[`BSB_FLAG_C] == ({1'b0, $past(st_reg.dval)} <
      {1'b0, $past(st_reg.sval)} + 9'($past(flags[`BSB_FLAG_C])))))
      else $error("subtract result or borrow wrong");
   a_bank_zero_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SEL_BANK0) |-> ##3 !bank_sel)
      else $error("bank flag not cleared");

   // ==========================================
   // instruction length, handshake, register writes and remaining flags
   a_sbc_short_cyc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SBC_RR) |->
      !instr_done [*4] ##1 instr_done)
      else $error("four cycle subtract length wrong");
   a_sbc_ind_cyc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SBC_RIR) |->
      !instr_done [*6] ##1 instr_done)
      else $error("indirect subtract length wrong");
   a_bank_zero_cyc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && instr_valid && opcode == `BSB_OP_SEL_BANK0) |->
      !instr_done [*4] ##1 instr_done)
      else $error("bank zero instruction length wrong");
   a_done_single: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_done |=> !instr_done)
      else $error("done pulse longer than one cycle");
   a_ready_after_done: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_done |-> instr_ready)
      else $error("not ready when instruction ends");
   a_busy_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state != BSB_IDLE) |=> (st_reg.cnt != 4'd1))
      else $error("request taken while busy");
   a_overflow_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state == BSB_EXEC && st_reg.is_sbc) |-> ##1 (flags[`BSB_FLAG_V] ==
      ((st_reg.dval[7] != st_reg.sval[7]) && (rf_wdata[7] == st_reg.sval[7]))))
      else $error("overflow flag mismatch");
   a_half_borrow: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state == BSB_EXEC && st_reg.is_sbc) |-> ##1 (flags[`BSB_FLAG_H] ==
      ({1'b0, st_reg.dval[3:0]} <
      {1'b0, st_reg.sval[3:0]} + 5'($past(flags[`BSB_FLAG_C])))))
      else $error("half borrow flag mismatch");
   a_write_target: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state == BSB_EXEC && st_reg.is_sbc) |->
      ##1 (rf_we && rf_waddr == st_reg.dst_a))
      else $error("result written to wrong register");
   a_ptr_unwritten: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state == BSB_EXEC && st_reg.is_sbc && st_reg.mode == BSB_SRC_INDIRECT &&
      st_reg.src_f != st_reg.dst_a) |-> ##1 (rf_waddr != st_reg.src_f))
      else $error("pointer register written");
   a_bank_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg.state == BSB_EXEC && !st_reg.is_sbc) |-> ##1 !rf_we)
      else $error("register write without subtract");
   a_flags_idle_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instr_ready && !instr_valid) |=> $stable(flags))
      else $error("flags changed while idle");
endmodule // bsb_core

// file: src/bsb_defs.svh
`ifndef BSB_DEFS_SVH
`define BSB_DEFS_SVH
// opcodes
`define BSB_OP_SEL_BANK1 8'h5F
`define BSB_OP_SEL_BANK0 8'h4F
`define BSB_OP_SBC_RR 8'h32
`define BSB_OP_SBC_RIR 8'h33
`define BSB_OP_SBC_GG 8'h34
`define BSB_OP_SBC_GIG 8'h35
`define BSB_OP_SBC_GIM 8'h36
// flags word bit positions
`define BSB_FLAG_C 7
`define BSB_FLAG_Z 6
`define BSB_FLAG_S 5
`define BSB_FLAG_V 4
`define BSB_FLAG_D 3
`define BSB_FLAG_H 2
`define BSB_FLAG_BANK 0
// instruction lengths in core cycles
`define BSB_CYC_SHORT 4'd4
`define BSB_CYC_LONG 4'd6
// reset value of the flags word
`define BSB_FLAGS_RST 8'h00
`endif

// file: src/bsb_pkg.sv
package bsb_pkg;
   typedef enum logic [1:0] {BSB_IDLE, BSB_FETCH, BSB_EXEC, BSB_DONE} bsb_state_e;
   typedef enum logic [1:0] {BSB_SRC_DIRECT, BSB_SRC_INDIRECT, BSB_SRC_IMM} bsb_src_e;
endpackage

// file: src/bsb_sbc_alu.sv
`timescale 1ns/1ps
`include "bsb_defs.svh"
// combinational subtract-with-borrow datapath
module bsb_sbc_alu
   import bsb_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic [W-1:0] dst,
   input wire logic [W-1:0] src,
   input wire logic carry_in,
   output logic [W-1:0] result,
   output logic borrow,
   output logic half_borrow,
   output logic overflow
);
   logic [W:0] sum;
   logic [4:0] low_sum;
   // add two's complement of src and carry: dst + ~src + !c
   always_comb
   begin
      sum = {1'b0, dst} + {1'b0, ~src} + {{W{1'b0}}, ~carry_in};
      low_sum = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'b0000, ~carry_in};
      result = sum[W-1:0];
      borrow = ~sum[W];
      half_borrow = ~low_sum[4];
      overflow = (dst[W-1] != src[W-1]) && (sum[W-1] == src[W-1]);
   end
endmodule // bsb_sbc_alu

// file: bench/bank_select_and_subtract_borrow_tb.sv
`timescale 1ns/1ps
module bank_select_and_subtract_borrow_tb;
   import bsb_pkg::*;
   typedef struct {logic [7:0] op; logic [7:0] da; logic [7:0] sf; logic [7:0] dv; int cyc;} bsb_row_s;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [7:0] dst_addr = 8'h00;
   logic [7:0] src_field = 8'h00;
   logic [7:0] rf_rdata, rf_raddr, rf_waddr, rf_wdata, flags, last_waddr, last_wdata;
   logic instr_ready, instr_done, rf_we, bank_sel;
   logic [7:0] rf [0:255];
   int mismatches = 0;
   int n_compared = 0;
   int n_writes = 0;
   bsb_row_s rows [12] = '{'{8'h36, 8'h01, 8'h8A, 8'h20, 6}, '{8'h36, 8'h01, 8'h8A, 8'h20, 6},
      '{8'h5F, 8'h00, 8'h00, 8'h00, 4}, '{8'h32, 8'h05, 8'h02, 8'h10, 4},
      '{8'h33, 8'h05, 8'h02, 8'h10, 6}, '{8'h34, 8'h06, 8'h03, 8'h0A, 6},
      '{8'h35, 8'h07, 8'h02, 8'h80, 6}, '{8'h4F, 8'h00, 8'h00, 8'h00, 4},
      '{8'h36, 8'h08, 8'h00, 8'h00, 6}, '{8'h36, 8'h08, 8'h01, 8'h00, 6},
      '{8'h34, 8'h09, 8'h04, 8'h7F, 6}, '{8'h10, 8'h0A, 8'h00, 8'h00, 6}};

   bsb_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .opcode(opcode), .dst_addr(dst_addr), .src_field(src_field), .instr_ready(instr_ready),
      .instr_done(instr_done), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we),
      .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .flags(flags), .bank_sel(bank_sel));

   // ==========================================
   // clock and register file
   always #50 core_clk = ~core_clk;
   assign rf_rdata = rf[rf_raddr];
   always @(posedge core_clk)
   begin
      if (rf_we === 1'b1)
      begin
         rf[rf_waddr] <= rf_wdata;
         last_waddr <= rf_waddr;
         last_wdata <= rf_wdata;
         n_writes <= n_writes + 1;
      end
   end

   // ==========================================
   // checking
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // expected {result, flags} from dst, src and previous flags
   function automatic logic [15:0] model(input logic [7:0] op, pf, d, s);
      logic [8:0] df;
      logic [4:0] lo;
      df = {1'b0, d} - {1'b0, s} - {8'h00, pf[7]};
      lo = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, pf[7]};
      if (op == 8'h5F)
         return {d, pf[7:1], 1'b1};
      if (op == 8'h4F)
         return {d, pf[7:1], 1'b0};
      // any other opcode outside the subtract range is a no-op
      if (op < 8'h32 || op > 8'h36)
         return {d, pf};
      return {df[7:0], df[8], df[7:0] == 8'h00, df[7], (d[7] != s[7]) && (df[7] == s[7]),
         1'b1, lo[4], pf[1:0]};
   endfunction

   task automatic wait_done(output int n);
      n = 0;
      while (n < 20)
      begin
         @(posedge core_clk);
         n++;
         #1;
         if (instr_done === 1'b1)
            break;
      end
   endtask

   task automatic run(input bsb_row_s r);
      logic [7:0] s, er, ef;
      int n, w0;
      rf[r.da] = r.dv;
      s = (r.op == 8'h33 || r.op == 8'h35) ? rf[rf[r.sf]] : (r.op == 8'h36) ? r.sf : rf[r.sf];
      {er, ef} = model(r.op, flags, r.dv, s);
      w0 = n_writes;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      opcode <= r.op;
      dst_addr <= r.da;
      src_field <= r.sf;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      wait_done(n);
      // the write issued with the done pulse lands at the next edge
      @(posedge core_clk);
      #1;
      chk(8'(n), 8'(r.cyc - 1));
      chk(flags, ef);
      chk({7'h00, bank_sel}, {7'h00, ef[0]});
      if (r.op < 8'h32 || r.op > 8'h36)
         chk(8'(n_writes - w0), 8'h00);
      else
      begin
         chk(8'(n_writes - w0), 8'h01);
         chk(last_waddr, r.da);
         chk(last_wdata, er);
      end
   endtask

   // ==========================================
   // sequence
   initial
   begin
      int n;
      for (int i = 0; i < 256; i++)
         rf[i] = 8'(i) ^ 8'h5A;
      rf[8'h02] = 8'h03;
      rf[8'h03] = 8'h0A;
      rf[8'h04] = 8'hFF;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk(flags, 8'h00);
      foreach (rows[i])
         run(rows[i]);
      // request while busy must be ignored
      @(posedge core_clk);
      instr_valid <= 1'b1;
      opcode <= 8'h5F;
      @(posedge core_clk);
      opcode <= 8'h4F;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      wait_done(n);
      chk(8'(n), 8'h02);
      repeat (8) @(posedge core_clk);
      #1;
      chk({7'h00, bank_sel}, 8'h01);
      // reset in mid-run clears the flags word
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk(flags, 8'h00);
      chk({6'h00, instr_ready, rf_we}, 8'h02);
      run(rows[0]);
      wrap_up;
   end

   initial
   begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      wrap_up;
   end
endmodule // bank_select_and_subtract_borrow_tb
